/* File: bench/icc_top_properties.sv */
`timescale 1ns/1ps
module icc_top_checker #(
    parameter logic [icc_pkg::PC_W-1:0] EXC_PC = icc_pkg::EXC_PC_DEFAULT
) (
    // Clock, reset, enable
    input wire logic                                             clock,
    input wire logic                                             rst_n,
    input wire logic                                             ce,
    // Instruction queue
    input wire logic [icc_pkg::SLOTS-1:0]                        iqValid,
    input wire logic [icc_pkg::SLOTS-1:0]                        iqBranch,
    input wire logic [icc_pkg::SLOTS-1:0]                        iqPredTaken,
    input wire logic [icc_pkg::SLOTS-1:0][icc_pkg::PC_W-1:0]     iqTargetPc,
    input wire logic [icc_pkg::SLOTS-1:0]                        iqTake,
    // Fetch, units, write-back
    input wire logic                                             fetchRedirect,
    input wire logic [icc_pkg::PC_W-1:0]                         fetchPc,
    input wire logic [icc_pkg::NUM_UNITS-1:0]                    unitBusy,
    input wire logic [icc_pkg::NUM_UNITS-1:0]                    opReady,
    input wire logic [icc_pkg::NUM_UNITS-1:0]                    issueValid,
    input wire logic [icc_pkg::NUM_UNITS-1:0]                    finValid,
    input wire logic [icc_pkg::SLOTS-1:0]                        wbValid,
    input wire logic [icc_pkg::SLOTS-1:0][icc_pkg::DATA_W-1:0]   wbData,
    input wire logic                                             excTaken
);
    import icc_pkg::*;
    logic finSeen_reg;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            finSeen_reg <= 1'b0;
        end else if (|finValid) begin
            finSeen_reg <= 1'b1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || !ce);
    a_take_from_valid: assert property (iqTake[0] |-> $past(iqValid[0]))
        else $error("take without a valid oldest slot");
    a_second_with_first: assert property (iqTake[1] |-> iqTake[0])
        else $error("second slot taken alone");
    a_take_spacing: assert property (iqTake != '0 |=> iqTake == '0)
        else $error("dispatch on consecutive edges");
    a_fold_redirect: assert property (iqTake[0] && iqBranch[0] && iqPredTaken[0]
        |-> fetchRedirect && fetchPc == iqTargetPc[0] && !iqTake[1])
        else $error("taken branch not folded");
    a_redirect_quiet: assert property (fetchRedirect |=> iqTake == '0)
        else $error("dispatch after redirect");
    a_issue_when_ready: assert property (|issueValid
        |-> (issueValid & $past(opReady & ~unitBusy)) == issueValid)
        else $error("issue to busy unit");
    a_wb_after_finish: assert property (wbValid[0] |-> $past(finSeen_reg))
        else $error("write-back with no finish before it");
    a_wb_data_holds: assert property (!wbValid[0] |-> $stable(wbData[0]))
        else $error("wb data changed without retire");
    a_exc_restart: assert property (excTaken |-> fetchRedirect && fetchPc == EXC_PC)
        else $error("exception without restart fetch");
endmodule
bind icc_top icc_top_checker #(.EXC_PC(EXC_PC)) u_icc_top_checker (.clock, .rst_n, .ce,
    .iqValid, .iqBranch, .iqPredTaken, .iqTargetPc, .iqTake, .fetchRedirect, .fetchPc,
    .unitBusy, .opReady, .issueValid, .finValid, .wbValid, .wbData, .excTaken);

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import icc_pkg::*;
    typedef struct packed {
        icc_unit_t         unit;
        icc_cls_t          cls;
        logic [REG_W-1:0]  dst;
        logic [DATA_W-1:0] data;
    } icc_row_t;
    localparam logic [PC_W-1:0] TB_EXC_PC = 32'h0000_0200;
    localparam logic [PC_W-1:0] TGT_PC    = 32'h0000_4000;
    localparam logic [PC_W-1:0] ALT_PC    = 32'h0000_8000;
    localparam icc_row_t ROWS [4] = '{'{ICC_UNIT_INT, ICC_CLS_GPR, 5'h01, 32'hA5A5_0001},
        '{ICC_UNIT_FP, ICC_CLS_FPR, 5'h1F, 32'h5A5A_0002},
        '{ICC_UNIT_VEC, ICC_CLS_VR, 5'h00, 32'hFFFF_0003},
        '{ICC_UNIT_INT, ICC_CLS_VR, 5'h10, 32'h0000_0004}};
    logic                                clock = 1'b0;
    logic                                rst_n = 1'b0;
    logic                                ce = 1'b1;
    logic [SLOTS-1:0]                    iqValid = '0, iqHasDst = '0, iqBranch = '0;
    logic [SLOTS-1:0]                    iqPredTaken = '0, iqTake, wbValid;
    logic [SLOTS-1:0][UNIT_W-1:0]        iqUnit = '0;
    logic [SLOTS-1:0][1:0]               iqCls = '0, wbCls;
    logic [SLOTS-1:0][REG_W-1:0]         iqDst = '0, wbIdx;
    logic [SLOTS-1:0][PC_W-1:0]          iqTargetPc = '0, iqAltPc = '0;
    logic [SLOTS-1:0][DATA_W-1:0]        wbData;
    logic                                fetchRedirect, excTaken, wbOk;
    logic [PC_W-1:0]                     fetchPc;
    logic [NUM_UNITS-1:0]                unitBusy = '0, opReady = '1, finValid = '0;
    logic [NUM_UNITS-1:0]                finExc = '0, issueValid;
    logic [NUM_UNITS-1:0][CQ_PTR-1:0]    finTag = '0, issueTag;
    logic [NUM_UNITS-1:0][DATA_W-1:0]    finData = '0;
    logic                                brResolve = 1'b0, brTaken = 1'b0;
    logic [CQ_PTR-1:0]                   nextTag = '0;
    int                                  n_mismatch = 0, checks = 0;
    icc_top #(.EXC_PC(TB_EXC_PC)) u_icc_top (.clock, .rst_n, .ce, .iqValid, .iqUnit, .iqCls,
        .iqHasDst, .iqDst, .iqBranch, .iqPredTaken, .iqTargetPc, .iqAltPc, .iqTake,
        .fetchRedirect, .fetchPc, .unitBusy, .opReady, .issueValid, .issueTag, .finValid,
        .finTag, .finData, .finExc, .brResolve, .brTaken, .wbValid, .wbCls, .wbIdx, .wbData,
        .excTaken);
    always #20 clock = ~clock;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // Bounded wait: 0 dispatch, 1 issue on unit u, 2 write-back
    task automatic await(input int k, input int u);
        for (int i = 0; i < 30; i++) begin
            if (k == 0 ? iqTake !== '0
                : (k == 1 ? issueValid[u] === 1'b1 : wbValid[0] === 1'b1)) return;
            step(1);
        end
        n_mismatch++;
        $display("unexpected at %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic put(input int s, input icc_unit_t u, input icc_cls_t c,
                       input logic [REG_W-1:0] d, input logic br, input logic pt);
        iqValid[s] = 1'b1;
        iqUnit[s] = u;
        iqCls[s] = c;
        iqDst[s] = d;
        iqHasDst[s] = !br;
        iqBranch[s] = br;
        iqPredTaken[s] = pt;
    endtask
    task automatic takeChk(input logic [SLOTS-1:0] exp);
        await(0, 0);
        chk(iqTake === exp, "dispatch slots");
    endtask
    task automatic pop;
        step(1);
        iqValid = '0;
    endtask
    task automatic fin(input int u, input logic [DATA_W-1:0] d);
        finValid[u] = 1'b1;
        finTag[u] = nextTag;
        finData[u] = d;
        step(1);
        finValid = '0;
    endtask
    initial begin
        step(5);
        chk(iqTake === '0 && fetchPc === '0 && wbValid === '0 && excTaken === 1'b0, "reset");
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            put(0, ROWS[i].unit, ROWS[i].cls, ROWS[i].dst, 1'b0, 1'b0);
            takeChk(2'h1);
            pop();
            await(1, ROWS[i].unit);
            chk(issueTag[ROWS[i].unit] === nextTag, "issue tag");
            chk(wbValid === '0, "write-back before finish");
            fin(ROWS[i].unit, ROWS[i].data);
            await(2, 0);
            chk(wbCls[0] === ROWS[i].cls && wbIdx[0] === ROWS[i].dst, "wb target");
            chk(wbData[0] === ROWS[i].data, "wb data");
            nextTag++;
        end
        // Fall-through branch, busy unit, correct prediction
        opReady = '0;
        unitBusy[0] = 1'b1;
        put(0, ICC_UNIT_INT, ICC_CLS_GPR, 5'h02, 1'b1, 1'b0);
        put(1, ICC_UNIT_INT, ICC_CLS_GPR, 5'h03, 1'b0, 1'b0);
        takeChk(2'h3);
        pop();
        put(0, ICC_UNIT_INT, ICC_CLS_GPR, 5'h04, 1'b0, 1'b0);
        repeat (6) begin step(1); chk(iqTake === '0, "station overrun"); end
        iqValid = '0;
        opReady[0] = 1'b1;
        repeat (4) begin step(1); chk(issueValid === '0, "issue while busy"); end
        unitBusy = '0;
        await(1, 0);
        chk(issueTag[0] === nextTag, "branch took a slot");
        brResolve = 1'b1;
        step(1);
        brResolve = 1'b0;
        fin(0, 32'hC0DE_0006);
        await(2, 0);
        chk(wbData[0] === 32'hC0DE_0006, "speculative result lost");
        nextTag++;
        // Misprediction
        opReady = '0;
        put(0, ICC_UNIT_INT, ICC_CLS_GPR, 5'h00, 1'b1, 1'b0);
        put(1, ICC_UNIT_FP, ICC_CLS_FPR, 5'h05, 1'b0, 1'b0);
        iqAltPc[0] = ALT_PC;
        takeChk(2'h3);
        pop();
        brResolve = 1'b1;
        brTaken = 1'b1;
        step(1);
        brResolve = 1'b0;
        chk(fetchRedirect === 1'b1 && fetchPc === ALT_PC, "refetch path");
        opReady = '1;
        fin(1, 32'hDEAD_0005);
        repeat (6) begin step(1); chk(wbValid === '0 && issueValid === '0, "purge"); end
        // Folded taken branch
        put(0, ICC_UNIT_INT, ICC_CLS_GPR, 5'h00, 1'b1, 1'b1);
        put(1, ICC_UNIT_INT, ICC_CLS_GPR, 5'h06, 1'b0, 1'b0);
        iqTargetPc[0] = TGT_PC;
        takeChk(2'h1);
        chk(fetchRedirect === 1'b1 && fetchPc === TGT_PC, "fold target");
        pop();
        brResolve = 1'b1;
        step(1);
        brResolve = 1'b0;
        // Older write-back, younger exception
        put(0, ICC_UNIT_INT, ICC_CLS_GPR, 5'h07, 1'b0, 1'b0);
        put(1, ICC_UNIT_FP, ICC_CLS_FPR, 5'h08, 1'b0, 1'b0);
        takeChk(2'h3);
        pop();
        await(1, 0);
        step(1);
        chk(issueTag[1] === nextTag + 3'h1, "pair order");
        finValid = 3'h3;
        finTag[0] = nextTag;
        finTag[1] = nextTag + 3'h1;
        finData[0] = 32'h1234_0007;
        finExc[1] = 1'b1;
        step(1);
        finValid = '0;
        finExc = '0;
        wbOk = 1'b0;
        for (int i = 0; i < 10; i++) begin
            step(1);
            if (wbValid[0] === 1'b1) wbOk = (wbData[0] === 32'h1234_0007);
            if (excTaken === 1'b1) break;
        end
        chk(excTaken === 1'b1 && wbOk === 1'b1, "older write-back");
        chk(fetchRedirect === 1'b1 && fetchPc === TB_EXC_PC, "exception restart");
        step(2);
        chk(wbData[0] === 32'h1234_0007, "write-back flushed");
        print_verdict();
    end
endmodule

/* File: hdl/icc_pkg.sv */
package icc_pkg;

    // Completion queue geometry
    localparam int CQ_DEPTH = 8;
    localparam int CQ_PTR   = 3;
    localparam int CQ_PW    = CQ_PTR + 1;
    localparam logic [CQ_PW-1:0] CQ_ROOM1 = 4'h7;
    localparam logic [CQ_PW-1:0] CQ_ROOM2 = 4'h6;
    localparam logic [CQ_PW-1:0] CQ_PTR_RESET = 4'h0;

    // Datapath widths
    localparam int DATA_W = 32;
    localparam int PC_W   = 32;
    localparam int REG_W  = 5;

    // Execution units behind the dispatcher
    localparam int NUM_UNITS  = 3;
    localparam int UNIT_W     = 2;
    localparam int UNIT_SLOTS = 4;
    localparam int SLOTS      = 2;

    // Arbitrary default restart address after an exception
    localparam logic [PC_W-1:0] EXC_PC_DEFAULT = 32'h0000_0100;

    typedef enum logic [1:0] {
        ICC_UNIT_INT = 2'h0,
        ICC_UNIT_FP  = 2'h1,
        ICC_UNIT_VEC = 2'h2
    } icc_unit_t;

    typedef enum logic [1:0] {
        ICC_CLS_GPR = 2'h0,
        ICC_CLS_FPR = 2'h1,
        ICC_CLS_VR  = 2'h2
    } icc_cls_t;

    typedef enum logic {
        ICC_ST_RUN     = 1'h0,
        ICC_ST_RECOVER = 1'h1
    } icc_state_t;

endpackage

/* File: hdl/icc_resv_station.sv */
`timescale 1ns/1ps
module icc_resv_station #(
    parameter int TAG_W = 3
) (
    // Clock and control
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             kill,
    // Dispatch side
    input  wire logic             inValid,
    input  wire logic [TAG_W-1:0] inTag,
    output logic                  ready,
    // Execution unit side
    input  wire logic             opReady,
    input  wire logic             unitBusy,
    output logic                  issueValid,
    output logic [TAG_W-1:0]      issueTag
);
    logic             held_reg;
    logic             issue_reg;
    logic [TAG_W-1:0] tag_reg;

    assign ready      = ~held_reg;
    assign issueValid = issue_reg;
    assign issueTag   = tag_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            held_reg  <= 1'b0;
            issue_reg <= 1'b0;
        end else if (ce) begin
            issue_reg <= 1'b0;
            if (kill) begin
                held_reg <= 1'b0;
            end else if (held_reg && opReady && !unitBusy) begin
                issue_reg <= 1'b1;
                held_reg  <= 1'b0;
            end else if (inValid && !held_reg) begin
                held_reg <= 1'b1;
            end
        end
    end

    // Tag stays put after issue so the unit can read it with the pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tag_reg <= '0;
        end else if (ce && inValid && !held_reg && !kill) begin
            tag_reg <= inTag;
        end
    end

endmodule

/* File: hdl/icc_top.sv */
`timescale 1ns/1ps
// Operation
// - A predicted not-taken branch is dropped at dispatch, no unit, no queue slot.
// - The finishing cycle marks the instruction's completion queue slot as done.
// - Retire only finished entries with results held; retiring frees the slot.
// - Retire only when neither this nor any older entry can still except.
// - Misprediction purges wrong-path entries and results and, only in state ICC_ST_RUN, refetches the other path.
// - Correct prediction lets following speculative entries go on to retire.
// - Taken-predicted branch and its fall-through are replaced by target instructions.
// - Completion slot allocated in the same cycle the instruction goes to its unit's reservation station.
// - Each unit has a station that accepts work before its operands are ready.
// - Finished but unretired results live in rename buffers, not architectural state.
// - Results are written to the architectural registers when the entry retires.
// - Write-back registers are never cleared by a flush.
// - All older instructions write back before an exception is taken.
// - A unit busy for several cycles stalls younger work aimed at it.
// - At most two retire per cycle, from the two oldest queue positions.
// - Dispatch at most two per cycle, only from the two oldest queue slots.
// - An instruction waits when no queue slot is free or its unit is full.
// - An excepting head entry cancels younger work and, only in state ICC_ST_RUN, refetches the right stream.
module icc_top #(
    parameter logic [icc_pkg::PC_W-1:0] EXC_PC = icc_pkg::EXC_PC_DEFAULT
) (
    // Clock, reset, enable
    input  wire logic                                            clock,
    input  wire logic                                            rst_n,
    input  wire logic                                            ce,
    // Instruction queue, slot 0 is the oldest
    input  wire logic [icc_pkg::SLOTS-1:0]                       iqValid,
    input  wire logic [icc_pkg::SLOTS-1:0][icc_pkg::UNIT_W-1:0]  iqUnit,
    input  wire logic [icc_pkg::SLOTS-1:0][1:0]                  iqCls,
    input  wire logic [icc_pkg::SLOTS-1:0]                       iqHasDst,
    input  wire logic [icc_pkg::SLOTS-1:0][icc_pkg::REG_W-1:0]   iqDst,
    input  wire logic [icc_pkg::SLOTS-1:0]                       iqBranch,
    input  wire logic [icc_pkg::SLOTS-1:0]                       iqPredTaken,
    input  wire logic [icc_pkg::SLOTS-1:0][icc_pkg::PC_W-1:0]    iqTargetPc,
    input  wire logic [icc_pkg::SLOTS-1:0][icc_pkg::PC_W-1:0]    iqAltPc,
    output logic [icc_pkg::SLOTS-1:0]                            iqTake,
    // Fetch steering
    output logic                                                 fetchRedirect,
    output logic [icc_pkg::PC_W-1:0]                             fetchPc,
    // Execution units
    input  wire logic [icc_pkg::NUM_UNITS-1:0]                   unitBusy,
    input  wire logic [icc_pkg::NUM_UNITS-1:0]                   opReady,
    output logic [icc_pkg::NUM_UNITS-1:0]                        issueValid,
    output logic [icc_pkg::NUM_UNITS-1:0][icc_pkg::CQ_PTR-1:0]   issueTag,
    input  wire logic [icc_pkg::NUM_UNITS-1:0]                   finValid,
    input  wire logic [icc_pkg::NUM_UNITS-1:0][icc_pkg::CQ_PTR-1:0] finTag,
    input  wire logic [icc_pkg::NUM_UNITS-1:0][icc_pkg::DATA_W-1:0] finData,
    input  wire logic [icc_pkg::NUM_UNITS-1:0]                   finExc,
    // Branch unit resolution
    input  wire logic                                            brResolve,
    input  wire logic                                            brTaken,
    // Architectural write-back and exception
    output logic [icc_pkg::SLOTS-1:0]                            wbValid,
    output logic [icc_pkg::SLOTS-1:0][1:0]                       wbCls,
    output logic [icc_pkg::SLOTS-1:0][icc_pkg::REG_W-1:0]        wbIdx,
    output logic [icc_pkg::SLOTS-1:0][icc_pkg::DATA_W-1:0]       wbData,
    output logic                                                 excTaken
);
    import icc_pkg::*;

    // Completion queue storage
    logic              cqValid [CQ_DEPTH];
    logic              cqDone  [CQ_DEPTH];
    logic              cqExc   [CQ_DEPTH];
    logic              cqSpec  [CQ_DEPTH];
    logic              cqHasDst[CQ_DEPTH];
    logic [1:0]        cqCls   [CQ_DEPTH];
    logic [REG_W-1:0]  cqDst   [CQ_DEPTH];
    logic [DATA_W-1:0] renameData[CQ_DEPTH];

    logic [CQ_PW-1:0]  head_reg;
    logic [CQ_PW-1:0]  tail_reg;
    logic [CQ_PW-1:0]  brTail_reg;
    logic              brPending_reg;
    logic              brPred_reg;
    logic [PC_W-1:0]   brAlt_reg;
    icc_state_t        state_reg;
    logic [SLOTS-1:0]  iqTake_reg;
    logic              fetchRedirect_reg;
    logic [PC_W-1:0]   fetchPc_reg;
    logic              excTaken_reg;
    logic [SLOTS-1:0]  wbValid_reg;
    logic [SLOTS-1:0][1:0]        wbCls_reg;
    logic [SLOTS-1:0][REG_W-1:0]  wbIdx_reg;
    logic [SLOTS-1:0][DATA_W-1:0] wbData_reg;

    logic [CQ_PW-1:0]  used;
    logic [SLOTS-1:0][CQ_PTR-1:0] hIdx;
    logic [SLOTS-1:0]  retire;
    logic [CQ_PTR-1:0] tIdxA;
    logic [CQ_PTR-1:0] tIdxB;
    logic              mispredict;
    logic              flushAll;
    logic              purge;
    logic              canGo;
    logic              take0;
    logic              take1;
    logic              allocA;
    logic              allocB;
    logic              fold;
    logic              brNew;
    logic              brSlot1;
    logic              specB;
    logic [NUM_UNITS-1:0]  stReady;
    logic [UNIT_SLOTS-1:0] unitFree;
    logic [NUM_UNITS-1:0]  stIn;
    logic [NUM_UNITS-1:0]  stKill;
    logic [NUM_UNITS-1:0][CQ_PTR-1:0] stInTag;

    assign iqTake        = iqTake_reg;
    assign fetchRedirect = fetchRedirect_reg;
    assign fetchPc       = fetchPc_reg;
    assign excTaken      = excTaken_reg;
    assign wbValid       = wbValid_reg;
    assign wbCls         = wbCls_reg;
    assign wbIdx         = wbIdx_reg;
    assign wbData        = wbData_reg;

    assign used    = tail_reg - head_reg;
    assign hIdx[0] = head_reg[CQ_PTR-1:0];
    assign hIdx[1] = hIdx[0] + 1'b1;
    assign tIdxA   = tail_reg[CQ_PTR-1:0];
    assign tIdxB   = tIdxA + {{(CQ_PTR-1){1'b0}}, allocA};

    // Only the two oldest entries may leave, and the second only behind the first
    assign retire[0] = cqValid[hIdx[0]] && cqDone[hIdx[0]]
                       && !cqExc[hIdx[0]] && !cqSpec[hIdx[0]];
    assign retire[1] = retire[0] && cqValid[hIdx[1]] && cqDone[hIdx[1]]
                       && !cqExc[hIdx[1]] && !cqSpec[hIdx[1]];

    // Older entries have all retired by the time the faulting one is at the head
    assign flushAll   = cqValid[hIdx[0]] && cqDone[hIdx[0]]
                        && cqExc[hIdx[0]] && !cqSpec[hIdx[0]];
    assign mispredict = brResolve && brPending_reg && (brTaken != brPred_reg);
    assign purge      = mispredict && !flushAll;

    assign canGo    = (state_reg == ICC_ST_RUN) && (iqTake_reg == '0)
                      && !flushAll && !mispredict;
    assign unitFree = UNIT_SLOTS'(stReady);

    // Dispatch from the two oldest slots, one instruction per unit per cycle
    always_comb begin
        take0   = 1'b0;
        take1   = 1'b0;
        allocA  = 1'b0;
        allocB  = 1'b0;
        fold    = 1'b0;
        brNew   = 1'b0;
        brSlot1 = 1'b0;
        if (canGo && iqValid[0]) begin
            if (iqBranch[0]) begin
                if (!brPending_reg) begin
                    take0 = 1'b1;
                    brNew = 1'b1;
                    fold  = iqPredTaken[0];
                end
            end else if (used <= CQ_ROOM1 && unitFree[iqUnit[0]]) begin
                take0  = 1'b1;
                allocA = 1'b1;
            end
        end
        if (take0 && !fold && iqValid[1]) begin
            if (iqBranch[1]) begin
                if (!brPending_reg && !iqBranch[0]) begin
                    take1   = 1'b1;
                    brNew   = 1'b1;
                    brSlot1 = 1'b1;
                    fold    = iqPredTaken[1];
                end
            end else if (unitFree[iqUnit[1]] && !(allocA && iqUnit[1] == iqUnit[0])
                         && (allocA ? used <= CQ_ROOM2 : used <= CQ_ROOM1)) begin
                take1  = 1'b1;
                allocB = 1'b1;
            end
        end
    end

    assign specB = brPending_reg || (brNew && !brSlot1);

    // Reservation station per unit
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        assign stIn[u] = (allocA && iqUnit[0] == UNIT_W'(u))
                         || (allocB && iqUnit[1] == UNIT_W'(u));
        assign stInTag[u] = (allocA && iqUnit[0] == UNIT_W'(u)) ? tIdxA : tIdxB;
        assign stKill[u]  = flushAll || (purge && cqSpec[issueTag[u]]);

        icc_resv_station #(
            .TAG_W (CQ_PTR)
        ) u_station (
            .clock      (clock),
            .rst_n      (rst_n),
            .ce         (ce),
            .kill       (stKill[u]),
            .inValid    (stIn[u]),
            .inTag      (stInTag[u]),
            .ready      (stReady[u]),
            .opReady    (opReady[u]),
            .unitBusy   (unitBusy[u]),
            .issueValid (issueValid[u]),
            .issueTag   (issueTag[u])
        );
    end

    // Completion queue entries
    for (genvar e = 0; e < CQ_DEPTH; e++) begin : g_cq
        logic hitA;
        logic hitB;
        logic leave;
        assign hitA  = allocA && tIdxA == CQ_PTR'(e);
        assign hitB  = allocB && tIdxB == CQ_PTR'(e);
        assign leave = (retire[0] && hIdx[0] == CQ_PTR'(e))
                       || (retire[1] && hIdx[1] == CQ_PTR'(e));

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                cqValid[e] <= 1'b0;
                cqDone[e]  <= 1'b0;
                cqExc[e]   <= 1'b0;
                cqSpec[e]  <= 1'b0;
            end else if (ce) begin
                if (flushAll || (purge && cqSpec[e])) begin
                    cqValid[e] <= 1'b0;
                end else if (hitA || hitB) begin
                    cqValid[e] <= 1'b1;
                    cqDone[e]  <= 1'b0;
                    cqExc[e]   <= 1'b0;
                    cqSpec[e]  <= hitA ? brPending_reg : specB;
                end else if (leave) begin
                    cqValid[e] <= 1'b0;
                end
                if (brResolve && brPending_reg && !mispredict) begin
                    cqSpec[e] <= 1'b0;
                end
                for (int u = 0; u < NUM_UNITS; u++) begin
                    if (finValid[u] && finTag[u] == CQ_PTR'(e) && cqValid[e] && !cqDone[e]) begin
                        cqDone[e] <= 1'b1;
                        cqExc[e]  <= finExc[u];
                    end
                end
            end
        end

        // Payload: destination and rename buffer, no reset needed
        always_ff @(posedge clock) begin
            if (ce) begin
                if (hitA || hitB) begin
                    cqHasDst[e] <= hitA ? iqHasDst[0] : iqHasDst[1];
                    cqCls[e]    <= hitA ? iqCls[0] : iqCls[1];
                    cqDst[e]    <= hitA ? iqDst[0] : iqDst[1];
                end
                for (int u = 0; u < NUM_UNITS; u++) begin
                    if (finValid[u] && finTag[u] == CQ_PTR'(e) && cqValid[e] && !cqDone[e]) begin
                        renameData[e] <= finData[u];
                    end
                end
            end
        end
    end

    // Head and tail pointers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            head_reg <= CQ_PTR_RESET;
            tail_reg <= CQ_PTR_RESET;
        end else if (ce) begin
            head_reg <= head_reg + CQ_PW'(retire[0]) + CQ_PW'(retire[1]);
            if (flushAll) begin
                tail_reg <= head_reg;
            end else if (purge) begin
                tail_reg <= brTail_reg;
            end else begin
                tail_reg <= tail_reg + CQ_PW'(allocA) + CQ_PW'(allocB);
            end
        end
    end

    // One outstanding predicted branch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            brPending_reg <= 1'b0;
            brPred_reg    <= 1'b0;
            brAlt_reg     <= '0;
            brTail_reg    <= CQ_PTR_RESET;
        end else if (ce) begin
            if (flushAll || (brResolve && brPending_reg)) begin
                brPending_reg <= 1'b0;
            end else if (brNew) begin
                brPending_reg <= 1'b1;
                brPred_reg    <= iqPredTaken[brSlot1];
                brAlt_reg     <= iqAltPc[brSlot1];
                brTail_reg    <= tail_reg + CQ_PW'(brSlot1 && allocA);
            end
        end
    end

    // Fetch redirect and recovery state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fetchRedirect_reg <= 1'b0;
            fetchPc_reg       <= '0;
            state_reg         <= ICC_ST_RUN;
        end else if (ce) begin
            fetchRedirect_reg <= 1'b0;
            case (state_reg)
                ICC_ST_RUN: begin
                    if (flushAll) begin
                        fetchRedirect_reg <= 1'b1;
                        fetchPc_reg       <= EXC_PC;
                        state_reg         <= ICC_ST_RECOVER;
                    end else if (mispredict) begin
                        fetchRedirect_reg <= 1'b1;
                        fetchPc_reg       <= brAlt_reg;
                        state_reg         <= ICC_ST_RECOVER;
                    end else if (fold) begin
                        fetchRedirect_reg <= 1'b1;
                        fetchPc_reg       <= iqTargetPc[brSlot1];
                        state_reg         <= ICC_ST_RECOVER;
                    end
                end
                ICC_ST_RECOVER: begin
                    state_reg <= ICC_ST_RUN;
                end
                default: begin
                    state_reg <= ICC_ST_RUN;
                end
            endcase
        end
    end

    // Slot pops and exception pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            iqTake_reg   <= '0;
            excTaken_reg <= 1'b0;
        end else if (ce) begin
            iqTake_reg   <= {take1, take0};
            excTaken_reg <= flushAll;
        end
    end

    // Architectural write-back; flushes never touch these
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wbValid_reg <= '0;
            wbCls_reg   <= '0;
            wbIdx_reg   <= '0;
            wbData_reg  <= '0;
        end else if (ce) begin
            for (int i = 0; i < SLOTS; i++) begin
                wbValid_reg[i] <= retire[i] && cqHasDst[hIdx[i]];
                if (retire[i] && cqHasDst[hIdx[i]]) begin
                    wbCls_reg[i]  <= cqCls[hIdx[i]];
                    wbIdx_reg[i]  <= cqDst[hIdx[i]];
                    wbData_reg[i] <= renameData[hIdx[i]];
                end
            end
        end
    end

endmodule
